// [supply_integrity_pkg.sv]
/*
 Constants for the supply integrity monitor: register offset,
 field positions, reset values, reset sequencer timing and states.
 Assumes nothing of its surroundings.
*/
package supply_integrity_pkg;

   // Register map, byte address on APB
   localparam logic [7:0] INTEGRITY_CTRL_STATUS_OFS = 8'h00;

   // Field positions inside the control/status register
   localparam int AUX_SOURCE_SELECT_BIT = 7;
   localparam int AUX_IRQ_ENABLE_BIT = 6;
   localparam int AUX_DETECT_FLAG_BIT = 5;
   localparam int LOW_SUPPLY_RESET_FLAG_BIT = 4;
   localparam int WATCHDOG_RESET_FLAG_BIT = 0;

   // Reset values of the stored bits
   localparam logic RST_AUX_SOURCE_SELECT = 1'h0;
   localparam logic RST_AUX_IRQ_ENABLE = 1'h0;
   localparam logic RST_LOW_SUPPLY_RESET_FLAG = 1'h0;
   localparam logic RST_WATCHDOG_RESET_FLAG = 1'h0;

   // Threshold choices for the low-supply detector
   localparam logic [1:0] LEVEL_LOW = 2'h0;
   localparam logic [1:0] LEVEL_MEDIUM = 2'h1;
   localparam logic [1:0] LEVEL_HIGH = 2'h2;

   // Reset delay phase, in CPU clock cycles
   localparam int DELAY_SHORT_CYCLES = 256;
   localparam int DELAY_LONG_CYCLES = 4096;
   localparam int DELAY_CNT_W = 13;

   // Reset sequencer states
   typedef enum logic [1:0] {
      SEQ_RUN = 2'b00,
      SEQ_ACTIVE = 2'b01,
      SEQ_DELAY = 2'b10
   } seq_state_t;

endpackage

// [level_sync.sv]
/*
 Two-flop synchroniser for a group of independent levels.
 Assumes each bit is a slow level; bits are not coherent as a word.
*/
`timescale 1ns/1ns
`default_nettype none
module level_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Levels
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage1; // Read only by the second stage

   ////////////////////////////////////////////////////////////////
   // One pair of flops per bit
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++)
      begin : g_bit
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               stage1[i] <= 1'b0;
               sync_out[i] <= 1'b0;
            end
            else
            begin
               stage1[i] <= async_in[i];
               sync_out[i] <= stage1[i];
            end
         end
      end
   endgenerate

endmodule // level_sync
`default_nettype wire

// [supply_integrity_monitor.sv]
/*
 Supply integrity monitor: low-supply reset sequencing, auxiliary
 voltage detector flag and interrupt, reset source flags, APB slave.
 Assumes analog comparators and option bits arrive as async levels,
 watchdog, CPU mask, halt/wait and ISR entry on pclk. presetn is the
 power-on reset of this block only; the system reset is an output.
*/
`timescale 1ns/1ns
`default_nettype none
module supply_integrity_monitor
   import supply_integrity_pkg::*;
#(
   parameter int DELAY_SHORT = DELAY_SHORT_CYCLES,
   parameter int DELAY_LONG = DELAY_LONG_CYCLES
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Analog comparators, async, high means voltage low
   input wire logic low_supply_cmp,
   input wire logic aux_cmp_supply,
   input wire logic aux_cmp_pin,
   // Non-volatile option bits, async levels
   input wire logic lvd_enable_opt,
   input wire logic [1:0] lvd_level_opt,
   input wire logic long_delay_opt,
   // External reset pin, open drain
   input wire logic reset_pin_in,
   output logic reset_pin_out,
   output logic reset_pin_oe,
   // System side, on pclk
   input wire logic watchdog_reset_req,
   input wire logic cpu_int_mask,
   input wire logic isr_enter,
   input wire logic halt_mode,
   input wire logic wait_mode,
   // Outputs to system and analog
   output logic system_reset,
   output logic aux_irq,
   output logic wait_wakeup,
   output logic [1:0] lvd_level_sel,
   output logic aux_source_sel
);

   ////////////////////////////////////////////////////////////////
   // Synchronisers
   logic [6:0] raw_in; // Async inputs grouped
   logic [6:0] sync_in; // Same, after two flops
   logic low_supply_s; // Supply below threshold
   logic aux_supply_s; // Aux comparator on supply
   logic aux_pin_s; // Aux comparator on monitor pin
   logic lvd_enabled; // Option: detector on
   logic [1:0] level_opt_s; // Option: threshold
   logic long_delay_s; // Option: long delay
   logic pin_low_s; // Reset pin seen low

   assign raw_in = {~reset_pin_in & ~reset_pin_oe, long_delay_opt, lvd_level_opt,
                    lvd_enable_opt, aux_cmp_pin, aux_cmp_supply};

   // Comparators and pin pass two flops first
   level_sync #(
      .WIDTH(7)
   ) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(raw_in),
      .sync_out(sync_in)
   );

   // Low-supply comparator on its own pair of flops
   level_sync #(
      .WIDTH(1)
   ) u_sync_lvd (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(low_supply_cmp),
      .sync_out(low_supply_s)
   );

   assign aux_supply_s = sync_in[0];
   assign aux_pin_s = sync_in[1];
   assign lvd_enabled = sync_in[2];
   assign level_opt_s = sync_in[4:3];
   assign long_delay_s = sync_in[5];
   assign pin_low_s = sync_in[6];

   ////////////////////////////////////////////////////////////////
   // Reset sources
   seq_state_t state; // Sequencer state
   seq_state_t next_state; // Its next value
   logic [DELAY_CNT_W-1:0] delay_cnt; // Delay phase counter
   logic [DELAY_CNT_W-1:0] delay_last; // Final count value
   logic lvd_reset; // Low-supply reset active
   logic wdg_reset; // Watchdog request
   logic ext_reset; // External pin pulled low
   logic any_reset; // Any source active
   logic delay_done; // Delay phase over

   // Detector ignored when not enabled by option
   assign lvd_reset = lvd_enabled & low_supply_s;
   assign wdg_reset = watchdog_reset_req;
   // Pin only counts while running; own pull masked before sync
   assign ext_reset = pin_low_s & (state == SEQ_RUN);
   assign any_reset = lvd_reset | wdg_reset | ext_reset;

   // Delay length from option, long or short
   assign delay_last = long_delay_s
      ? DELAY_CNT_W'(DELAY_LONG - 1)
      : DELAY_CNT_W'(DELAY_SHORT - 1);
   assign delay_done = (delay_cnt == delay_last);

   // Next state: a low supply always wins and restarts
   always_comb
   begin
      next_state = state;
      unique case (state)
         SEQ_RUN:
            if (any_reset)
               next_state = SEQ_ACTIVE;
         SEQ_ACTIVE:
            // Stay static while the supply is low
            if (!lvd_reset && !wdg_reset)
               next_state = SEQ_DELAY;
         SEQ_DELAY:
            if (lvd_reset || wdg_reset)
               next_state = SEQ_ACTIVE;
            else if (delay_done)
               next_state = SEQ_RUN;
         default:
            next_state = SEQ_ACTIVE;
      endcase
   end

   // State register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state <= SEQ_ACTIVE;
      else
         state <= next_state;
   end

   // Delay counter, cleared outside the delay phase
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         delay_cnt <= '0;
      else if (state != SEQ_DELAY || delay_done)
         delay_cnt <= '0;
      else
         delay_cnt <= delay_cnt + 1'b1;
   end

   // System reset and pin pull-down: whole active and delay phases
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         system_reset <= 1'b1;
         reset_pin_oe <= 1'b1;
         reset_pin_out <= 1'b0;
      end
      else
      begin
         system_reset <= (next_state != SEQ_RUN);
         reset_pin_oe <= (next_state != SEQ_RUN);
         reset_pin_out <= 1'b0;
      end
   end

   // Threshold choice to the analog detector
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         lvd_level_sel <= LEVEL_HIGH;
      else if (level_opt_s == LEVEL_LOW || level_opt_s == LEVEL_MEDIUM)
         lvd_level_sel <= level_opt_s;
      else
         // Unused code falls back to the safest level
         lvd_level_sel <= LEVEL_HIGH;
   end

   ////////////////////////////////////////////////////////////////
   // APB decode
   logic setup_phase; // First cycle of a transfer
   logic hit; // Address is the register
   logic wr_en; // Write takes effect now
   logic aux_irq_enable; // Stored interrupt enable
   logic aux_detect_flag; // Real-time aux flag
   logic low_supply_reset_flag; // Last reset was low supply
   logic watchdog_reset_flag; // Last reset was watchdog
   logic [7:0] reg_view; // Register as read

   assign setup_phase = psel & ~penable;
   assign hit = (paddr == INTEGRITY_CTRL_STATUS_OFS);
   // Writes ignored in halt, register frozen
   assign wr_en = psel & penable & pready & pwrite & hit
                & ~halt_mode;

   // Reserved bits 3:1 read as zero
   assign reg_view = {aux_source_sel, aux_irq_enable,
      aux_detect_flag, low_supply_reset_flag & lvd_enabled,
      3'h0, watchdog_reset_flag & lvd_enabled};

   // One wait-free answer: ready and data set in setup cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else
      begin
         pready <= setup_phase;
         pslverr <= setup_phase & ~hit;
         // Unmapped reads answer zero
         prdata <= (setup_phase & hit) ? {24'h00_0000, reg_view}
                                       : 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Software control bits
   // Source select and interrupt enable
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         aux_source_sel <= RST_AUX_SOURCE_SELECT;
         aux_irq_enable <= RST_AUX_IRQ_ENABLE;
      end
      else if (wr_en)
      begin
         aux_source_sel <= pwdata[AUX_SOURCE_SELECT_BIT];
         aux_irq_enable <= pwdata[AUX_IRQ_ENABLE_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////
   // Reset source flags
   logic lvd_entry; // Entering active phase from low supply
   logic wdg_entry; // Watchdog reset event
   logic clr_lvd_flag; // Software writes zero
   logic clr_wdg_flag; // Software writes zero

   assign lvd_entry = lvd_reset & (state != SEQ_ACTIVE);
   assign wdg_entry = wdg_reset & (state != SEQ_ACTIVE);
   assign clr_lvd_flag = wr_en & ~pwdata[LOW_SUPPLY_RESET_FLAG_BIT];
   assign clr_wdg_flag = wr_en & ~pwdata[WATCHDOG_RESET_FLAG_BIT];

   // Low-supply flag: set wins, survives other resets
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         low_supply_reset_flag <= RST_LOW_SUPPLY_RESET_FLAG;
      else if (lvd_entry)
         low_supply_reset_flag <= 1'b1;
      else if (clr_lvd_flag)
         low_supply_reset_flag <= 1'b0;
   end

   // Watchdog flag: low supply clears it for a stable start
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         watchdog_reset_flag <= RST_WATCHDOG_RESET_FLAG;
      else if (lvd_reset)
         watchdog_reset_flag <= 1'b0;
      else if (wdg_entry)
         watchdog_reset_flag <= 1'b1;
      else if (clr_wdg_flag)
         watchdog_reset_flag <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////
   // Auxiliary detector flag and interrupt
   logic aux_source_level; // Selected comparator
   logic next_aux_flag; // Flag value to load
   logic flag_toggle; // Flag changes this cycle
   logic enable_rise; // Enable written 0 to 1
   logic irq_event; // Pending request set
   logic aux_pending; // Pending request

   assign aux_source_level = aux_source_sel ? aux_pin_s
                                            : aux_supply_s;
   // Forced clear while the detector is disabled
   assign next_aux_flag = aux_source_level & lvd_enabled;
   assign flag_toggle = (next_aux_flag != aux_detect_flag);
   assign enable_rise = wr_en & pwdata[AUX_IRQ_ENABLE_BIT]
                      & ~aux_irq_enable;

   // A toggle while in reset raises nothing; enabling with the
   // flag already set counts as one event
   assign irq_event = lvd_enabled & ~system_reset & (
      (flag_toggle & ~halt_mode & aux_irq_enable)
      | (enable_rise & aux_detect_flag));

   // Flag tracks comparator, held while halted
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         aux_detect_flag <= 1'b0;
      else if (!halt_mode)
         aux_detect_flag <= next_aux_flag;
   end

   // Pending request: set wins over ISR-entry clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         aux_pending <= 1'b0;
      else if (irq_event)
         aux_pending <= 1'b1;
      else if (isr_enter || !aux_irq_enable)
         aux_pending <= 1'b0;
   end

   // Request to CPU and wake from wait; halt is never left here
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         aux_irq <= 1'b0;
         wait_wakeup <= 1'b0;
      end
      else
      begin
         aux_irq <= aux_pending & aux_irq_enable
                  & ~cpu_int_mask & ~isr_enter;
         wait_wakeup <= aux_pending & aux_irq_enable
                      & wait_mode & ~halt_mode;
      end
   end

endmodule // supply_integrity_monitor
`default_nettype wire

// [supply_integrity_monitor_asserts.sv]
/*
 Port checker for the supply integrity monitor.
 Assumes it is bound onto the monitor and sees only its ports.
*/
`timescale 1ns/1ns
`default_nettype none
module supply_integrity_monitor_asserts
   import supply_integrity_pkg::*;
#(
   parameter int DELAY_SHORT = DELAY_SHORT_CYCLES,
   parameter int DELAY_LONG = DELAY_LONG_CYCLES
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Analog and option levels
   input wire logic low_supply_cmp,
   input wire logic lvd_enable_opt,
   input wire logic [1:0] lvd_level_opt,
   // Reset pin
   input wire logic reset_pin_out,
   input wire logic reset_pin_oe,
   // System side
   input wire logic cpu_int_mask,
   input wire logic isr_enter,
   input wire logic halt_mode,
   input wire logic wait_mode,
   input wire logic system_reset,
   input wire logic aux_irq,
   input wire logic wait_wakeup,
   input wire logic [1:0] lvd_level_sel,
   input wire logic aux_source_sel
);
   // One domain, so one clock and one disable for all
   default clocking main_clk @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////////////////
   // Four samples cover two sync flops and the output flop
   chk_reset_hold: assert property ((lvd_enable_opt && low_supply_cmp)[*4] |-> system_reset && reset_pin_oe)
      else $error("reset not held on low supply");
   // Open drain: only ever pulls low
   chk_pin_level: assert property (reset_pin_oe |-> !reset_pin_out)
      else $error("reset pin driven high");
   // Request reaches the core only when unmasked
   chk_irq_mask: assert property (aux_irq |-> $past(!cpu_int_mask))
      else $error("interrupt while masked");
   // Entry to the service routine drops the request
   chk_isr_clear: assert property (isr_enter |=> !aux_irq)
      else $error("request kept after service entry");
   // Wake from wait, never from halt
   chk_wake_halt: assert property (wait_wakeup |-> $past(wait_mode && !halt_mode))
      else $error("wake outside wait");
   // Source select bit frozen in halt
   chk_halt_frozen: assert property (halt_mode |=> $stable(aux_source_sel))
      else $error("register changed in halt");
   // Threshold select follows the option, code 3 means high; syncs start at zero
   chk_level_sel: assert property ($stable(lvd_level_opt)[*5] |->
      lvd_level_sel == ((lvd_level_opt == 2'h3) ? LEVEL_HIGH : lvd_level_opt))
      else $error("threshold select wrong");
   // Reset never ends before the short delay has passed
   chk_delay_len: assert property ($fell(system_reset) |-> $past(system_reset, DELAY_SHORT))
      else $error("reset delay too short");
endmodule // supply_integrity_monitor_asserts
bind supply_integrity_monitor supply_integrity_monitor_asserts #(.DELAY_SHORT(DELAY_SHORT), .DELAY_LONG(DELAY_LONG))
   chk_u (.pclk(pclk), .presetn(presetn), .low_supply_cmp(low_supply_cmp), .lvd_enable_opt(lvd_enable_opt),
   .lvd_level_opt(lvd_level_opt), .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
   .cpu_int_mask(cpu_int_mask), .isr_enter(isr_enter), .halt_mode(halt_mode), .wait_mode(wait_mode),
   .system_reset(system_reset), .aux_irq(aux_irq), .wait_wakeup(wait_wakeup),
   .lvd_level_sel(lvd_level_sel), .aux_source_sel(aux_source_sel));
`default_nettype wire

// [supply_integrity_monitor_tb.sv]
/*
 Self-checking bench for the supply integrity monitor.
 Assumes the monitor, its package and shortened reset delays.
*/
`timescale 1ns/1ns
`default_nettype none
module supply_integrity_monitor_tb
   import supply_integrity_pkg::*;
();
   localparam int DLS = 4;
   localparam int DLL = 16;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, v, d;
   logic low_supply_cmp, aux_cmp_supply, aux_cmp_pin, lvd_enable_opt, long_delay_opt;
   logic [1:0] lvd_level_opt, lvd_level_sel;
   logic reset_pin_out, reset_pin_oe, watchdog_reset_req, cpu_int_mask, isr_enter, halt_mode, wait_mode;
   logic system_reset, aux_irq, wait_wakeup, aux_source_sel;
   logic ext_pin_low, pin_level;
   // Open-drain pin with pull-up: low if either side pulls
   assign pin_level = !(reset_pin_oe && !reset_pin_out) && !ext_pin_low;
   int fails, checked, ls, ll;
   // Pin input from the open-drain model above
   supply_integrity_monitor #(.DELAY_SHORT(DLS), .DELAY_LONG(DLL)) dut_u (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .low_supply_cmp, .aux_cmp_supply, .aux_cmp_pin,
      .lvd_enable_opt, .lvd_level_opt, .long_delay_opt, .reset_pin_in(pin_level), .reset_pin_out, .reset_pin_oe,
      .watchdog_reset_req, .cpu_int_mask, .isr_enter, .halt_mode, .wait_mode, .system_reset, .aux_irq,
      .wait_wakeup, .lvd_level_sel, .aux_source_sel);
   ////////////////////////////////////////////////////////////////////////
   // Clock, 4 ns period
   initial
   begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   // Expected register image
   function automatic logic [31:0] exp_reg(input logic s, ie, f, lf, wf);
      return {24'h0, s, ie, f, lf, 3'h0, wf};
   endfunction
   // Expected threshold select
   function automatic logic [1:0] exp_level(input logic [1:0] o);
      return (o == 2'h3) ? LEVEL_HIGH : o;
   endfunction
   // Compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("wrong value at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   // Verdict and end of run
   task automatic finish_test();
      if (fails == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // One APB transfer; request held until pready at an edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1)
         fails++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wreg(input logic [31:0] wd);
      apb(1'b1, INTEGRITY_CTRL_STATUS_OFS, wd, v);
   endtask
   task automatic rreg();
      apb(1'b0, INTEGRITY_CTRL_STATUS_OFS, 32'h0, v);
   endtask
   // Bounded waits on the design's own outputs
   task automatic run_len(output int len);
      len = 0;
      while (system_reset !== 1'b0 && len < 9000)
      begin
         @(posedge pclk);
         len++;
      end
      if (system_reset !== 1'b0)
         fails++;
   endtask
   task automatic wait_irq();
      int n;
      n = 0;
      while (aux_irq !== 1'b1 && n < 40)
      begin
         @(posedge pclk);
         n++;
      end
   endtask
   task automatic isr_pulse();
      @(posedge pclk);
      isr_enter <= 1'b1;
      @(posedge pclk);
      isr_enter <= 1'b0;
      step(2);
   endtask
   // Watchdog reset, then length of the system reset
   task automatic wdg_len(output int len);
      @(posedge pclk);
      watchdog_reset_req <= 1'b1;
      @(posedge pclk);
      watchdog_reset_req <= 1'b0;
      step(3);
      run_len(len);
   endtask
   // Hang guard, well past the expected run
   initial
   begin
      #200000;
      fails++;
      finish_test();
   end
   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata, low_supply_cmp, aux_cmp_supply, aux_cmp_pin} = '0;
      {long_delay_opt, watchdog_reset_req, isr_enter, halt_mode, wait_mode, cpu_int_mask, ext_pin_low} = '0;
      lvd_enable_opt = 1'b1;
      lvd_level_opt = LEVEL_HIGH;
      fails = 0;
      checked = 0;
      v = $urandom(32'hAA166886);
      presetn = 1'b0;
      step(12);
      presetn <= 1'b1;
      run_len(ls);
      rreg();
      check(v, exp_reg(0, 0, 0, 0, 0));
      apb(1'b0, 8'h04, 32'h0, v);
      check(v, 32'h0000_0000);
      check({31'h0, err}, 32'h0000_0001);
      for (int i = 0; i < 4; i++)
      begin
         lvd_level_opt <= 2'(i);
         step(5);
         check(lvd_level_sel, exp_level(2'(i)));
      end
      // Random control writes; reserved bits kept clear
      for (int i = 0; i < 8; i++)
      begin
         d = $urandom & 32'hFFFFFFF1;
         wreg(d);
         rreg();
         check(v, exp_reg(d[7], d[6], 0, 0, 0));
         check(aux_source_sel, d[7]);
      end
      wreg(32'h0);
      aux_cmp_supply <= 1'b1;
      step(6);
      rreg();
      check(v, exp_reg(0, 0, 1, 0, 0));
      wreg(32'h80);
      step(4);
      rreg();
      check(v, exp_reg(1, 0, 0, 0, 0));
      aux_cmp_supply <= 1'b0;
      // Pin mode, both edges raise a request
      wreg(32'hC0);
      for (int i = 1; i >= 0; i--)
      begin
         aux_cmp_pin <= i[0];
         wait_irq();
         check(aux_irq, 1'b1);
         isr_pulse();
         check(aux_irq, 1'b0);
      end
      cpu_int_mask <= 1'b1;
      aux_cmp_pin <= 1'b1;
      step(8);
      check(aux_irq, 1'b0);
      cpu_int_mask <= 1'b0;
      wait_irq();
      check(aux_irq, 1'b1);
      wait_mode <= 1'b1;
      step(3);
      check(wait_wakeup, 1'b1);
      halt_mode <= 1'b1;
      step(3);
      check(wait_wakeup, 1'b0);
      wreg(32'h0);
      rreg();
      check(v, exp_reg(1, 1, 1, 0, 0));
      {halt_mode, wait_mode} <= 2'h0;
      isr_pulse();
      // Enabling with the flag already set
      wreg(32'h80);
      wreg(32'hC0);
      wait_irq();
      check(aux_irq, 1'b1);
      isr_pulse();
      wreg(32'h0);
      aux_cmp_pin <= 1'b0;
      step(6);
      // Low-supply reset; flag toggles only inside it
      wreg(32'h40);
      low_supply_cmp <= 1'b1;
      step(10);
      check(system_reset && reset_pin_oe, 1'b1);
      aux_cmp_supply <= 1'b1;
      step(6);
      {aux_cmp_supply, low_supply_cmp} <= 2'h0;
      run_len(ls);
      step(3);
      check(aux_irq, 1'b0);
      rreg();
      check(v, exp_reg(0, 1, 0, 1, 0));
      // External pin reset keeps the low-supply flag, no echo after release
      ext_pin_low <= 1'b1;
      step(6);
      check(system_reset, 1'b1);
      ext_pin_low <= 1'b0;
      run_len(ls);
      step(4);
      check(system_reset, 1'b0);
      rreg();
      check(v, exp_reg(0, 1, 0, 1, 0));
      wdg_len(ls);
      rreg();
      check(v, exp_reg(0, 1, 0, 1, 1));
      low_supply_cmp <= 1'b1;
      step(8);
      low_supply_cmp <= 1'b0;
      run_len(ls);
      rreg();
      check(v, exp_reg(0, 1, 0, 1, 0));
      wreg(32'h40);
      rreg();
      check(v, exp_reg(0, 1, 0, 0, 0));
      wdg_len(ls);
      rreg();
      check(v, exp_reg(0, 1, 0, 0, 1));
      long_delay_opt <= 1'b1;
      step(4);
      wdg_len(ll);
      check(ll - ls, DLL - DLS);
      // Detector disabled: no reset, no flags
      {lvd_enable_opt, low_supply_cmp, aux_cmp_supply} <= 3'h3;
      step(10);
      check(system_reset, 1'b0);
      check(aux_irq, 1'b0);
      rreg();
      check(v, exp_reg(0, 1, 0, 0, 0));
      finish_test();
   end
endmodule // supply_integrity_monitor_tb
`default_nettype wire
